// [rtl/occ_pkg.sv]
// package: constants and carriers for the operator console control block
package occ_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CHK_OFS = 8'h08;
    localparam logic [7:0] ATTN_OFS = 8'h0c;
    localparam logic [7:0] KBD_OFS = 8'h10;
    localparam logic [7:0] IAR_OFS = 8'h14;
    localparam logic [7:0] LOADCNT_OFS = 8'h18;
    // ctrl field positions
    localparam int CTRL_IL1EN_BIT = 0;
    localparam int CTRL_KACK_BIT = 1;
    localparam int CTRL_STEPMODE_BIT = 2;
    localparam int CTRL_LDCARD_BIT = 3;
    // keyboard inquiry values
    localparam logic [7:0] INQ_DATA = 8'h11;
    localparam int FKEY_BIT = 3;
    localparam logic [7:0] INQ_STATUS = 8'h08;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    // load record length in bytes, one sector
    localparam logic [15:0] SECTOR_BYTES = 16'h0100;
    // device classes for check and attention
    localparam int NCHK = 4;
    localparam int NATTN = 8;
    localparam logic [2:0] DEV_CRT = 3'h0;
    localparam logic [2:0] DEV_PRT = 3'h1;
    localparam logic [2:0] DEV_REC = 3'h2;
    localparam logic [2:0] DEV_KBD = 3'h3;
    localparam logic [2:0] DEV_SER = 3'h4;
    localparam logic [2:0] DEV_SCA = 3'h5;
    localparam logic [2:0] DEV_LCF = 3'h6;
    localparam logic [2:0] DEV_DSK = 3'h7;
    // load sequencer states
    typedef enum logic [3:0] {
        LD_IDLE = 4'b0001,
        LD_WAIT = 4'b0010,
        LD_READ = 4'b0100,
        LD_HOLD = 4'b1000
    } occ_load_e;
    // start io command carrier
    typedef struct packed {
        logic valid;
        logic [2:0] dev;
    } occ_sio_s;
    // sync comm adapter status carrier
    typedef struct packed {
        logic modemSetReadyInd;
        logic acuPowerOff;
        logic lineInUseInd;
        logic terminalReadyInd;
        logic externalLoopSwitch;
    } occ_sca_s;
endpackage

// [rtl/occ_console_ctrl.sv]
// operator console control: inquiry, program load, start/stop, checks
//
// Contract
// - inquiry switch on latches keyboard data and status bytes like a key.
// - inquiry status has function-key bit 3; data is 0001 0001.
// - inquiry always latches; its interrupt is requested only while interrupt level one is enabled.
// - disk select picks removable or fixed disk, cylinder 0 sector 0.
// - program load resets all registers except keyboard data/status bytes and io enable, and zeroes instruction and data address.
// - load reads the record into storage starting at address zero.
// - on load switch release, execution starts at address zero.
// - drive one not ready lights attention; load completes when ready.
// - online punch mode puts recorder under program, its keyboard disabled.
// - offline mode lets the recorder run standalone.
// - start switch clears halt codes and resumes processing.
// - stop halts at end of operation, lights stop; io completes.
// - power-on partial reset blocks io starts until requested.
// - io check sets on listed attachment errors.
// - io check clears on system reset, check reset, or own start io.
// - one attention per device class, set on start io while not ready; ledger feeder bit sets on ledgerInsertReq.
// - serial channel attention when device absent or not ready.
// - adapter attention on modem, auto call, line, terminal, loop switch.
// - adapter step mode advances one phase per step or start press.
// - ledger feeder attention when a card must be inserted.
`timescale 1ns/1ps
module occ_console_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // console switches (asynchronous)
    input wire logic inquirySw,
    input wire logic programLoadSw,
    input wire logic diskSelFixedSw,
    input wire logic cardRecorderSwitch,
    input wire logic recorderPunchSw,
    input wire logic startSw,
    input wire logic stopSw,
    input wire logic systemResetSw,
    input wire logic checkResetSw,
    input wire logic stepKeySw,
    // processor side, same clock
    input wire logic opDone,
    input wire occ_pkg::occ_sio_s start_io_command,
    input wire logic [7:0] devReady,
    input wire logic serialAttached,
    input wire occ_pkg::occ_sca_s scaStat,
    input wire logic ledgerInsertReq,
    input wire logic [3:0] chkErr,
    input wire logic diskRdValid,
    input wire logic [7:0] diskRdData,
    // outputs
    output logic haltCodeOn,
    output logic stopLight,
    output logic cpuRun,
    output logic ioEnable,
    output logic ioCheckLight,
    output logic ioAttnLight,
    output logic diskRdReq,
    output logic diskFixedSel,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [7:0] memData,
    output logic [15:0] iarOut,
    output logic kbdIntReq,
    output logic recorderProgCtl,
    output logic recorderKbdEn,
    output logic scaStep
);
    // two-flop synchronisers for all switch inputs
    localparam int NSW = 10;
    logic [NSW-1:0] swRaw, swMeta_r, swSync_r, swPrev_r;
    assign swRaw = {stepKeySw, checkResetSw, systemResetSw, stopSw, startSw,
        recorderPunchSw, cardRecorderSwitch, diskSelFixedSw, programLoadSw,
        inquirySw};
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            swMeta_r <= '0;
            swSync_r <= '0;
            swPrev_r <= '0;
        end else begin
            swMeta_r <= swRaw;
            swSync_r <= swMeta_r;
            swPrev_r <= swSync_r;
        end
    end
    // rising edges of synchronised switches
    wire [NSW-1:0] swRise = swSync_r & ~swPrev_r;
    wire inqRise = swRise[0];
    wire loadLvl = swSync_r[1];
    wire loadRise = swRise[1];
    wire loadFall = ~swSync_r[1] & swPrev_r[1];
    wire startRise = swRise[5];
    wire stopRise = swRise[6];
    wire sysRstRise = swRise[7];
    wire chkRstRise = swRise[8];
    wire stepRise = swRise[9];

    // apb decode
    logic [31:0] ctrl_r;
    wire apbWr = psel & penable & pwrite;
    wire hitCtrl = (paddr == occ_pkg::CTRL_OFS);
    wire hitStat = (paddr == occ_pkg::STAT_OFS);
    wire hitChk = (paddr == occ_pkg::CHK_OFS);
    wire hitAttn = (paddr == occ_pkg::ATTN_OFS);
    wire hitKbd = (paddr == occ_pkg::KBD_OFS);
    wire hitIar = (paddr == occ_pkg::IAR_OFS);
    wire hitCnt = (paddr == occ_pkg::LOADCNT_OFS);
    wire hitAny = hitCtrl | hitStat | hitChk | hitAttn | hitKbd | hitIar
        | hitCnt;
    wire ctrlWr = apbWr & hitCtrl;
    wire il1En = ctrl_r[occ_pkg::CTRL_IL1EN_BIT];
    wire kbdAck = ctrlWr & pwdata[occ_pkg::CTRL_KACK_BIT];
    wire stepMode = ctrl_r[occ_pkg::CTRL_STEPMODE_BIT];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hitAny;

    // load sequencer
    occ_pkg::occ_load_e ldSt_r, ldSt_nxt;
    logic [15:0] ldCnt_r;
    logic diskFixed_r;
    wire drvReady = devReady[occ_pkg::DEV_DSK];
    wire ldDone = diskRdValid && (ldCnt_r == occ_pkg::SECTOR_BYTES - 16'h1);
    // loadReset stands for system-level reset of registers and indicators
    wire loadReset = loadRise;
    wire sysClr = sysRstRise | loadReset;
    always_comb begin
        ldSt_nxt = ldSt_r;
        case (ldSt_r)
            occ_pkg::LD_IDLE: begin
                if (loadRise) ldSt_nxt = occ_pkg::LD_WAIT;
            end
            occ_pkg::LD_WAIT: begin
                if (drvReady) ldSt_nxt = occ_pkg::LD_READ;
            end
            occ_pkg::LD_READ: begin
                if (ldDone) ldSt_nxt = occ_pkg::LD_HOLD;
            end
            occ_pkg::LD_HOLD: begin
                if (!loadLvl) ldSt_nxt = occ_pkg::LD_IDLE;
            end
            default: ldSt_nxt = occ_pkg::LD_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ldSt_r <= occ_pkg::LD_IDLE;
        end else begin
            ldSt_r <= ldSt_nxt;
        end
    end
    // disk choice captured at load start
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            diskFixed_r <= 1'b0;
        end else if (loadRise) begin
            diskFixed_r <= swSync_r[2];
        end
    end
    // sector bytes go to storage from zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ldCnt_r <= occ_pkg::ADDR_ZERO;
        end else if (loadRise) begin
            ldCnt_r <= occ_pkg::ADDR_ZERO;
        end else if (ldSt_r == occ_pkg::LD_READ && diskRdValid) begin
            ldCnt_r <= ldCnt_r + 16'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            memWe <= 1'b0;
            memAddr <= occ_pkg::ADDR_ZERO;
            memData <= 8'h00;
        end else begin
            memWe <= (ldSt_r == occ_pkg::LD_READ) && diskRdValid;
            memAddr <= ldCnt_r;
            memData <= diskRdData;
        end
    end
    assign diskRdReq = (ldSt_r == occ_pkg::LD_READ);
    assign diskFixedSel = diskFixed_r;

    // instruction address held at zero through load
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            iarOut <= occ_pkg::ADDR_ZERO;
        end else if (sysClr || ldSt_r != occ_pkg::LD_IDLE) begin
            iarOut <= occ_pkg::ADDR_ZERO;
        end else if (apbWr && hitIar) begin
            iarOut <= pwdata[15:0];
        end
    end

    logic halted_r, stopPend_r, halt_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stopPend_r <= 1'b0;
            halted_r <= 1'b1;
            halt_r <= 1'b0;
        end else begin
            stopPend_r <= (stopPend_r | stopRise) & ~startRise & ~halted_r;
            if (startRise || loadFall) begin
                halted_r <= 1'b0;
            end else if ((stopPend_r && opDone) || sysClr) begin
                halted_r <= 1'b1;
            end
            if (startRise || sysClr) begin
                halt_r <= 1'b0;
            end else if (apbWr && hitStat) begin
                halt_r <= pwdata[0];
            end
        end
    end
    assign haltCodeOn = halt_r;
    assign stopLight = halted_r;
    assign cpuRun = ~halted_r & (ldSt_r == occ_pkg::LD_IDLE);

    // power-on partial reset, io blocked until a start io
    logic ioEn_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ioEn_r <= 1'b0;
        end else if (start_io_command.valid) begin
            ioEn_r <= 1'b1;
        end
    end
    assign ioEnable = ioEn_r;

    logic kbdPend_r;
    logic [7:0] kbdData_r, kbdStat_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kbdPend_r <= 1'b0;
            kbdData_r <= 8'h00;
            kbdStat_r <= 8'h00;
        end else if (inqRise) begin
            // inquiry codes; set wins over ack
            kbdPend_r <= 1'b1;
            kbdData_r <= occ_pkg::INQ_DATA;
            kbdStat_r <= occ_pkg::INQ_STATUS;
        end else if (kbdAck || sysClr) begin
            kbdPend_r <= 1'b0;
        end
    end
    assign kbdIntReq = kbdPend_r & il1En;

    wire recOnline = swSync_r[3];
    assign recorderProgCtl = recOnline & swSync_r[4];
    assign recorderKbdEn = ~recorderProgCtl;

    // adapter step pulse in step mode
    assign scaStep = stepMode & (stepRise | startRise);

    logic [occ_pkg::NCHK-1:0] chk_r;
    wire chkClrAll = sysClr | chkRstRise;
    genvar g;
    generate
        for (g = 0; g < occ_pkg::NCHK; g++) begin : gChk
            wire sioHit = start_io_command.valid && (start_io_command.dev == 3'(g));
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    chk_r[g] <= 1'b0;
                end else if (chkErr[g]) begin
                    chk_r[g] <= 1'b1;
                end else if (chkClrAll || sioHit) begin
                    chk_r[g] <= 1'b0;
                end
            end
        end
    endgenerate
    assign ioCheckLight = |chk_r;

    wire scaBad = ~scaStat.modemSetReadyInd | scaStat.acuPowerOff
        | scaStat.lineInUseInd | ~scaStat.terminalReadyInd
        | scaStat.externalLoopSwitch;
    logic [occ_pkg::NATTN-1:0] notReady, attn_r;
    always_comb begin
        notReady = ~devReady;
        notReady[occ_pkg::DEV_SER] = ~devReady[occ_pkg::DEV_SER]
            | ~serialAttached;
        // adapter conditions, on top of plain not ready
        notReady[occ_pkg::DEV_SCA] = ~devReady[occ_pkg::DEV_SCA] | scaBad;
    end
    generate
        for (g = 0; g < occ_pkg::NATTN; g++) begin : gAttn
            wire sioHit = start_io_command.valid && (start_io_command.dev == 3'(g));
            wire setA;
            if (g == occ_pkg::DEV_LCF) begin : gL
                assign setA = ledgerInsertReq;
            end else if (g == occ_pkg::DEV_DSK) begin : gD
                assign setA = (sioHit & notReady[g])
                    | (ldSt_r == occ_pkg::LD_WAIT & ~drvReady);
            end else begin : gO
                assign setA = sioHit & notReady[g];
            end
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    attn_r[g] <= 1'b0;
                end else if (setA) begin
                    attn_r[g] <= 1'b1;
                end else if (sysClr || (devReady[g] && !notReady[g])
                    || (sioHit && !notReady[g])) begin
                    attn_r[g] <= 1'b0;
                end
            end
        end
    endgenerate
    assign ioAttnLight = |attn_r;

    // ctrl register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= occ_pkg::CTRL_RST;
        end else if (sysClr) begin
            ctrl_r <= occ_pkg::CTRL_RST;
        end else if (ctrlWr) begin
            ctrl_r <= pwdata & 32'h0000_000d;
        end
    end

    // read mux
    wire [31:0] statWord = {24'h0, diskFixed_r, recorderProgCtl,
        ldSt_r, kbdPend_r, halted_r};
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hitCtrl) prdata <= ctrl_r;
            else if (hitStat) prdata <= statWord;
            else if (hitChk) prdata <= {28'h0, chk_r};
            else if (hitAttn) prdata <= {24'h0, attn_r};
            else if (hitKbd) prdata <= {16'h0, kbdStat_r, kbdData_r};
            else if (hitIar) prdata <= {16'h0, iarOut};
            else if (hitCnt) prdata <= {16'h0, ldCnt_r};
            else prdata <= 32'h0000_0000;
        end
    end

    // assertions
    property p_inq_codes;
        @(posedge sys_clk) disable iff (!arst_n)
        inqRise |=> kbdData_r == 8'h11 && kbdStat_r[3] && kbdPend_r;
    endproperty
    a_inq_codes: assert property (p_inq_codes) else $error("inquiry codes");
    property p_il1;
        @(posedge sys_clk) disable iff (!arst_n) !il1En |-> !kbdIntReq;
    endproperty
    a_il1: assert property (p_il1) else $error("inquiry without level one");
    property p_load_iar;
        @(posedge sys_clk) disable iff (!arst_n)
        ldSt_r == occ_pkg::LD_HOLD |=> iarOut == 16'h0000;
    endproperty
    a_load_iar: assert property (p_load_iar) else $error("iar not zero");
    property p_load_wait;
        @(posedge sys_clk) disable iff (!arst_n)
        ldSt_r == occ_pkg::LD_WAIT && !drvReady |=> attn_r[7];
    endproperty
    a_load_wait: assert property (p_load_wait) else $error("no disk attn");
    property p_start;
        @(posedge sys_clk) disable iff (!arst_n)
        startRise |=> !haltCodeOn && !stopLight;
    endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_stop;
        @(posedge sys_clk) disable iff (!arst_n)
        stopPend_r && opDone && !startRise |=> stopLight;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_chk;
        @(posedge sys_clk) disable iff (!arst_n)
        |chkErr |=> ioCheckLight;
    endproperty
    a_chk: assert property (p_chk) else $error("check not lit");
    property p_rec;
        @(posedge sys_clk) disable iff (!arst_n)
        recorderProgCtl |-> !recorderKbdEn;
    endproperty
    a_rec: assert property (p_rec) else $error("recorder keyboard on");
endmodule

// [dv/occ_disk_model.sv]
// disk drive one model: serves the load sector as a byte stream
`timescale 1ns/1ps
module occ_disk_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // request side
    input wire logic diskRdReq,
    input wire logic diskFixedSel,
    input wire logic [3:0] gapCycles,
    // byte stream
    output logic diskRdValid,
    output logic [7:0] diskRdData
);
    logic [8:0] idx_r;
    logic [3:0] gap_r;
    logic valid_r;
    logic [7:0] data_r;
    wire logic [7:0] pattern = idx_r[7:0] ^ (diskFixedSel ? 8'h3c : 8'ha5);
    wire logic more = diskRdReq && !idx_r[8];
    // one sector
    // idle data line inverts so a stale byte never passes for a fresh one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_r <= 9'h000;
            gap_r <= 4'h0;
            valid_r <= 1'b0;
            data_r <= 8'h00;
        end else if (more && gap_r == 4'h0) begin
            valid_r <= 1'b1;
            data_r <= pattern;
            idx_r <= idx_r + 9'h001;
            gap_r <= gapCycles;
        end else begin
            valid_r <= 1'b0;
            data_r <= ~data_r;
            if (!diskRdReq) idx_r <= 9'h000;
            if (gap_r != 4'h0) gap_r <= gap_r - 4'h1;
        end
    end
    // outputs straight from flops
    assign diskRdValid = valid_r;
    assign diskRdData = data_r;
endmodule

// [dv/test_operator_console_control.sv]
// self-checking bench for the operator console control block
`timescale 1ns/1ps
module test_operator_console_control;
    typedef struct packed {
        logic rd;
        logic [31:0] data;
        logic err;
    } occ_note_s;
    localparam logic [4:0] SCA_OK = 5'h12;
    logic sys_clk = 1'b0, arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, inquirySw = 0, programLoadSw = 0;
    logic diskSelFixedSw = 0, cardRecorderSwitch = 0, recorderPunchSw = 0;
    logic startSw = 0, stopSw = 0, systemResetSw = 0, checkResetSw = 0;
    logic stepKeySw = 0, opDone = 0, serialAttached = 1, ledgerInsertReq = 0;
    occ_pkg::occ_sio_s start_io_command = '0;
    occ_pkg::occ_sca_s scaStat = SCA_OK;
    logic [7:0] devReady = 8'h7f, diskRdData, memData;
    logic [3:0] chkErr = 4'h0, gapCycles = 4'h0;
    logic diskRdValid, haltCodeOn, stopLight, cpuRun, ioEnable, ioCheckLight;
    logic ioAttnLight, diskRdReq, diskFixedSel, memWe, kbdIntReq, scaStep;
    logic recorderProgCtl, recorderKbdEn;
    logic [15:0] memAddr, iarOut;
    occ_note_s apbQ[$];
    logic [23:0] memQ[$];
    int n_errors = 0, n_checks = 0, cycles = 0, stepCnt = 0;
    int seed = 32'haa6a78b1;
    logic [31:0] e, iv;

    occ_console_ctrl i_occ_console_ctrl (.sys_clk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .inquirySw,
        .programLoadSw, .diskSelFixedSw, .cardRecorderSwitch, .recorderPunchSw,
        .startSw, .stopSw, .systemResetSw, .checkResetSw, .stepKeySw, .opDone,
        .start_io_command, .devReady, .serialAttached, .scaStat, .ledgerInsertReq, .chkErr,
        .diskRdValid, .diskRdData, .haltCodeOn, .stopLight, .cpuRun, .ioEnable,
        .ioCheckLight, .ioAttnLight, .diskRdReq, .diskFixedSel, .memWe,
        .memAddr, .memData, .iarOut, .kbdIntReq, .recorderProgCtl,
        .recorderKbdEn, .scaStep);
    occ_disk_model i_occ_disk_model (.sys_clk, .arst_n, .diskRdReq,
        .diskFixedSel, .gapCycles, .diskRdValid, .diskRdData);

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bad(input string nm, input logic [31:0] x, logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask

    // watchers: apb answers, storage writes, step pulses, hang guard
    always @(posedge sys_clk) begin
        occ_note_s n;
        logic [23:0] m;
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            wrap_up();
        end
        if (scaStep === 1'b1) stepCnt++;
        if (psel && penable && pready === 1'b1 && apbQ.size() != 0) begin
            n = apbQ.pop_front();
            bad("pslverr", {31'h0, n.err}, {31'h0, pslverr});
            if (n.rd) bad("prdata", n.data, prdata);
        end
        if (memWe === 1'b1) begin
            m = (memQ.size() != 0) ? memQ.pop_front() : 24'hxxxxxx;
            bad("mem write", {8'h0, m}, {8'h0, memAddr, memData});
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one apb transfer; the expected answer is noted first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic err);
        int g;
        apbQ.push_back('{~w, x, err});
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge sys_clk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        if (pready !== 1'b1) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask

    task automatic sio_cmd(input int d);
        start_io_command <= {1'b1, d[2:0]};
        tick(1);
        start_io_command <= '0;
        tick(3);
    endtask

    task automatic pulse_chk();
        chkErr <= 4'hf;
        tick(1);
        chkErr <= 4'h0;
        tick(3);
    endtask

    task automatic sys_reset();
        systemResetSw <= 1'b1;
        tick(5);
        systemResetSw <= 1'b0;
        tick(4);
    endtask

    initial begin
        tick(3);
        arst_n <= 1'b1;
        rd(occ_pkg::CTRL_OFS, occ_pkg::CTRL_RST);
        rd(occ_pkg::STAT_OFS, 32'h05);
        rd(occ_pkg::IAR_OFS, 32'h0);
        rd(occ_pkg::LOADCNT_OFS, 32'h0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h40, 32'hffff_ffff, 32'h0, 1'b1);
        bad("stopLight", 1, stopLight);
        bad("ioEnable", 0, ioEnable);
        // start and stop
        wr(occ_pkg::STAT_OFS, 32'h1);
        tick(2);
        bad("haltCodeOn", 1, haltCodeOn);
        startSw <= 1'b1;
        tick(6);
        startSw <= 1'b0;
        bad("haltCodeOn", 0, haltCodeOn);
        bad("stopLight", 0, stopLight);
        bad("cpuRun", 1, cpuRun);
        stopSw <= 1'b1;
        tick(6);
        stopSw <= 1'b0;
        bad("stopLight", 0, stopLight);
        opDone <= 1'b1;
        tick(1);
        opDone <= 1'b0;
        tick(2);
        bad("stopLight", 1, stopLight);
        startSw <= 1'b1;
        tick(6);
        startSw <= 1'b0;
        // inquiry key
        inquirySw <= 1'b1;
        tick(6);
        bad("kbdIntReq", 0, kbdIntReq);
        rd(occ_pkg::KBD_OFS, {16'h0, occ_pkg::INQ_STATUS, 8'h11});
        rd(occ_pkg::STAT_OFS, 32'h06);
        wr(occ_pkg::CTRL_OFS, 32'h1);
        tick(2);
        bad("kbdIntReq", 1, kbdIntReq);
        wr(occ_pkg::CTRL_OFS, 32'h3);
        rd(occ_pkg::CTRL_OFS, 32'h1);
        bad("kbdIntReq", 0, kbdIntReq);
        inquirySw <= 1'b0;
        // recorder switch settings
        for (int i = 0; i < 4; i++) begin
            {cardRecorderSwitch, recorderPunchSw} <= i[1:0];
            tick(5);
            bad("recorderProgCtl", i == 3, recorderProgCtl);
            bad("recorderKbdEn", i != 3, recorderKbdEn);
        end
        {cardRecorderSwitch, recorderPunchSw} <= 2'b00;
        // adapter stepping, with and without step mode
        iv = stepCnt;
        for (int i = 0; i < 2; i++) begin
            wr(occ_pkg::CTRL_OFS, i ? 32'h0 : 32'h4);
            stepKeySw <= 1'b1;
            tick(6);
            stepKeySw <= 1'b0;
            startSw <= 1'b1;
            tick(6);
            startSw <= 1'b0;
            tick(4);
            bad("step pulses", 2, stepCnt - iv);
        end
        // program load from each disk, drive not ready at first
        for (int s = 0; s < 2; s++) begin
            gapCycles <= 4'($random(seed) & 3);
            devReady[7] <= 1'b0;
            diskSelFixedSw <= s[0];
            iv = $random(seed) | 32'h1;
            wr(occ_pkg::IAR_OFS, {16'h0, iv[15:0]});
            rd(occ_pkg::IAR_OFS, {16'h0, iv[15:0]});
            wr(occ_pkg::CTRL_OFS, 32'h4);
            pulse_chk();
            for (int a = 0; a < 256; a++)
                memQ.push_back({a[15:0], a[7:0] ^ (s ? 8'h3c : 8'ha5)});
            programLoadSw <= 1'b1;
            tick(6);
            rd(occ_pkg::CHK_OFS, 32'h0);
            rd(occ_pkg::IAR_OFS, 32'h0);
            rd(occ_pkg::CTRL_OFS, 32'h0);
            bad("diskRdReq", 0, diskRdReq);
            bad("ioAttnLight", 1, ioAttnLight);
            rd(occ_pkg::ATTN_OFS, 32'h80);
            devReady[7] <= 1'b1;
            for (int g = 0; g < 3000 && memQ.size() != 0; g++) tick(1);
            tick(2);
            bad("bytes left", 0, memQ.size());
            rd(occ_pkg::LOADCNT_OFS, 32'h100);
            bad("diskFixedSel", s, diskFixedSel);
            bad("cpuRun", 0, cpuRun);
            rd(occ_pkg::ATTN_OFS, 32'h0);
            programLoadSw <= 1'b0;
            tick(6);
            bad("iarOut", 0, iarOut);
            bad("cpuRun", 1, cpuRun);
        end
        // io checks: latch, per-device clear, check reset, system reset
        devReady <= 8'hff;
        pulse_chk();
        rd(occ_pkg::CHK_OFS, 32'hf);
        bad("ioCheckLight", 1, ioCheckLight);
        tick(20);
        rd(occ_pkg::CHK_OFS, 32'hf);
        bad("ioEnable", 0, ioEnable);
        e = 32'hf;
        for (int i = 0; i < 4; i++) begin
            sio_cmd(i);
            e[i] = 1'b0;
            rd(occ_pkg::CHK_OFS, e);
        end
        bad("ioEnable", 1, ioEnable);
        pulse_chk();
        checkResetSw <= 1'b1;
        tick(5);
        checkResetSw <= 1'b0;
        tick(3);
        rd(occ_pkg::CHK_OFS, 32'h0);
        pulse_chk();
        sys_reset();
        rd(occ_pkg::CHK_OFS, 32'h0);
        bad("ioCheckLight", 0, ioCheckLight);
        // attention per device class
        devReady <= 8'h80;
        e = 32'h0;
        for (int d = 0; d < 6; d++) begin
            sio_cmd(d);
            e[d] = 1'b1;
            rd(occ_pkg::ATTN_OFS, e);
        end
        bad("ioAttnLight", 1, ioAttnLight);
        devReady <= 8'hff;
        tick(3);
        rd(occ_pkg::ATTN_OFS, 32'h0);
        serialAttached <= 1'b0;
        sio_cmd(4);
        rd(occ_pkg::ATTN_OFS, 32'h10);
        serialAttached <= 1'b1;
        sys_reset();
        for (int k = 0; k < 5; k++) begin
            scaStat <= SCA_OK ^ (5'h1 << k);
            tick(1);
            sio_cmd(5);
            rd(occ_pkg::ATTN_OFS, 32'h20);
            scaStat <= SCA_OK;
            sys_reset();
            rd(occ_pkg::ATTN_OFS, 32'h0);
        end
        ledgerInsertReq <= 1'b1;
        tick(3);
        rd(occ_pkg::ATTN_OFS, 32'h40);
        ledgerInsertReq <= 1'b0;
        tick(5);
        wrap_up();
    end
endmodule
